//--- core/program_memory_mode_ext_bus.sv
/*
 Program memory mode selection and multiplexed external program bus.
 Assumes external address latches on the bus and an outside core that
 asks for fetches and table writes one per instruction cycle.
*/
// Operation
// - program fetch path apart from data
// - sixteen bit program counter, 64K words
// - reset fetch at zero, four vectors
// - four memory modes from configuration bits
// - internal only modes, unknown beyond end
// - protected mode turns on code protection
// - extended mode splits internal/external by address
// - microprocessor mode fetches all words externally
// - unprogrammed bits select microprocessor mode
// - gate configuration, test, boot memory access
// - data memory always stays on chip
// - two ports form bus, three control lines
// - extended internal fetch still toggles controls
// - external data ignored during internal fetch
`timescale 1ns/100ps
module program_memory_mode_ext_bus
  import pm_bus_pkg::*;
#(
  parameter int INT_WORDS = INT_MEM_WORDS
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [1:0] modeCfg,
  input wire logic vecLoad,
  input wire logic [1:0] vecSel,
  input wire logic jumpLoad,
  input wire logic [15:0] jumpAddr,
  input wire logic tblWrite,
  input wire logic [15:0] tblAddr,
  input wire logic [15:0] tblData,
  input wire logic specialReq,
  input wire logic [15:0] intWord,
  input wire logic [7:0] busLowByteIn,
  input wire logic [7:0] busHighByteIn,
  output logic [7:0] busLowByteOut,
  output logic [7:0] busHighByteOut,
  output logic [7:0] busLowByteOe,
  output logic [7:0] busHighByteOe,
  output logic [2:0] busControlOut,
  output logic [2:0] busControlOe,
  output logic [15:0] progCounter,
  output logic [15:0] intAddr,
  output logic intRead,
  output logic [15:0] fetchWord,
  output logic fetchValid,
  output logic codeProtect,
  output logic specialGrant,
  output logic [1:0] activeMode
);
  // =====================================================
  // state
  typedef struct packed {
    logic cfgTaken;
    pm_mode_e mode;
    logic [1:0] phase;
    logic [15:0] pc;
    logic [15:0] cycAddr;
    logic cycWrite;
    logic [15:0] cycData;
    logic cycInternal;
    logic [7:0] lowOut;
    logic [7:0] highOut;
    logic [7:0] lowOe;
    logic [7:0] highOe;
    logic [2:0] ctlOut;
    logic [2:0] ctlOe;
    logic [15:0] intAddr;
    logic intRead;
    logic [15:0] word;
    logic valid;
    logic protect;
    logic grant;
  } state_s;

  state_s st_q;
  state_s st_d;

  localparam logic [16:0] INT_LIMIT = 17'(INT_WORDS);

  // =====================================================
  // decode helpers
  // word address lies inside the implemented internal memory
  function automatic logic belowSplit(input logic [15:0] a);
    belowSplit = ({1'b0, a} < INT_LIMIT);
  endfunction

  // internal versus external by mode and word address
  function automatic logic isInternal(input pm_mode_e m, input logic [15:0] a);
    logic inRange;
    inRange = belowSplit(a);
    unique case (m)
      MODE_MICROPROC: begin
        isInternal = 1'b0;
      end
      MODE_EXTENDED: begin
        isInternal = inRange;
      end
      MODE_MICROCTRL, MODE_PROTECTED: begin
        isInternal = 1'b1;
      end
    endcase
  endfunction

  // modes that run the external bus
  function automatic logic drivesBus(input pm_mode_e m);
    drivesBus = (m == MODE_MICROPROC) || (m == MODE_EXTENDED);
  endfunction

  // modes that keep execution internal
  function automatic logic internalOnly(input pm_mode_e m);
    internalOnly = (m == MODE_MICROCTRL) || (m == MODE_PROTECTED);
  endfunction

  // interrupt entry point for a vector select
  function automatic logic [15:0] vectorFor(input logic [1:0] sel);
    logic [15:0] v;
    v = INT_VEC0;
    unique case (sel)
      2'h0: begin
        v = INT_VEC0;
      end
      2'h1: begin
        v = INT_VEC1;
      end
      2'h2: begin
        v = INT_VEC2;
      end
      2'h3: begin
        v = INT_VEC3;
      end
    endcase
    vectorFor = v;
  endfunction

  // =====================================================
  // next state
  always_comb begin
    logic [15:0] cycTarget;
    logic busMode;
    cycTarget = st_q.pc;
    busMode = 1'b0;
    st_d = st_q;
    st_d.valid = 1'b0;
    st_d.intRead = 1'b0;
    // =====================================================
    // mode, protection and special access
    // mode latched once after reset release, fixed thereafter
    if (!st_q.cfgTaken) begin
      st_d.cfgTaken = 1'b1;
      st_d.mode = pm_mode_e'(modeCfg);
    end
    if (st_q.cfgTaken && st_q.mode == MODE_PROTECTED) begin
      st_d.protect = 1'b1;
    end else begin
      st_d.protect = 1'b0;
    end
    if (specialReq && st_q.cfgTaken && internalOnly(st_q.mode)) begin
      st_d.grant = 1'b1;
    end else begin
      st_d.grant = 1'b0;
    end
    busMode = st_q.cfgTaken && drivesBus(st_q.mode);
    // =====================================================
    // phase sequencing
    // phases hold at the first slot until the mode is known
    if (st_q.cfgTaken) begin
      st_d.phase = st_q.phase + 2'h1;
    end else begin
      st_d.phase = PHASE_Q1;
    end
    if (tblWrite) begin
      cycTarget = tblAddr;
    end
    // =====================================================
    // bus cycle
    unique case (st_q.phase)
      PHASE_Q1: begin
        // start of instruction cycle: pick fetch or table write
        st_d.cycWrite = tblWrite;
        st_d.cycAddr = cycTarget;
        st_d.cycData = tblData;
        st_d.cycInternal = isInternal(st_q.mode, cycTarget);
        if (busMode) begin
          st_d.lowOut = cycTarget[7:0];
          st_d.highOut = cycTarget[15:8];
          st_d.lowOe = OE_DRIVE;
          st_d.highOe = OE_DRIVE;
          st_d.ctlOut = CTL_IDLE;
          st_d.ctlOut[CTL_ALE] = 1'b1;
        end
      end
      PHASE_Q2: begin
        st_d.ctlOut[CTL_ALE] = 1'b0;
        // address held in the external latches while outside stays off the bus
        if (busMode && !st_q.cycWrite) begin
          st_d.lowOe = OE_FLOAT;
          st_d.highOe = OE_FLOAT;
        end
        if (st_q.cycInternal) begin
          st_d.intAddr = st_q.cycAddr;
          st_d.intRead = !st_q.cycWrite;
        end
      end
      PHASE_Q3: begin
        if (busMode) begin
          if (st_q.cycWrite) begin
            st_d.lowOut = st_q.cycData[7:0];
            st_d.highOut = st_q.cycData[15:8];
            st_d.ctlOut[CTL_WR] = 1'b0;
          end else begin
            st_d.ctlOut[CTL_OE] = 1'b0;
          end
        end
      end
      PHASE_Q4: begin
        if (busMode) begin
          st_d.ctlOut = CTL_IDLE;
        end
        if (!st_q.cycWrite) begin
          if (st_q.cycInternal) begin
            st_d.word = intWord;
          end else begin
            st_d.word = {busHighByteIn, busLowByteIn};
          end
          st_d.valid = 1'b1;
        end
        if (vecLoad) begin
          st_d.pc = vectorFor(vecSel);
        end else if (jumpLoad) begin
          st_d.pc = jumpAddr;
        end else if (!st_q.cycWrite) begin
          st_d.pc = st_q.pc + 16'h0001;
        end
      end
    endcase
    // =====================================================
    // pad enables
    if (!busMode) begin
      st_d.lowOe = OE_FLOAT;
      st_d.highOe = OE_FLOAT;
      st_d.ctlOe = 3'h7;
    end else begin
      st_d.ctlOe = 3'h0;
    end
  end

  // =====================================================
  // registers; data memory is outside this block and always on chip
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{
        cfgTaken: 1'b0,
        mode: pm_mode_e'(CFG_UNPROGRAMMED),
        phase: PHASE_Q1,
        pc: RESET_VECTOR,
        cycAddr: RESET_VECTOR,
        cycWrite: 1'b0,
        cycData: 16'h0000,
        cycInternal: 1'b0,
        lowOut: 8'h00,
        highOut: 8'h00,
        lowOe: OE_FLOAT,
        highOe: OE_FLOAT,
        ctlOut: CTL_IDLE,
        ctlOe: 3'h7,
        intAddr: 16'h0000,
        intRead: 1'b0,
        word: 16'h0000,
        valid: 1'b0,
        protect: 1'b0,
        grant: 1'b0
      };
    end else begin
      st_q <= st_d;
    end
  end

  // =====================================================
  // outputs
  assign busLowByteOut = st_q.lowOut;
  assign busHighByteOut = st_q.highOut;
  assign busLowByteOe = st_q.lowOe;
  assign busHighByteOe = st_q.highOe;
  assign busControlOut = st_q.ctlOut;
  assign busControlOe = st_q.ctlOe;

  // =====================================================
  // core side
  assign progCounter = st_q.pc;
  assign intAddr = st_q.intAddr;
  assign intRead = st_q.intRead;
  assign fetchWord = st_q.word;
  assign fetchValid = st_q.valid;
  assign codeProtect = st_q.protect;
  assign specialGrant = st_q.grant;
  assign activeMode = st_q.mode;
endmodule

//--- core/pm_bus_pkg.sv
/*
 Constants for the program memory mode and external bus block.
 Assumes a four-phase instruction cycle generated from sys_clk.
*/
package pm_bus_pkg;
  // =====================================================
  // mode configuration encoding
  typedef enum logic [1:0] {
    MODE_MICROPROC = 2'h3,
    MODE_EXTENDED  = 2'h2,
    MODE_MICROCTRL = 2'h1,
    MODE_PROTECTED = 2'h0
  } pm_mode_e;
  localparam logic [1:0] CFG_UNPROGRAMMED = 2'h3;
  // =====================================================
  // vectors
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] INT_VEC0 = 16'h0008;
  localparam logic [15:0] INT_VEC1 = 16'h0010;
  localparam logic [15:0] INT_VEC2 = 16'h0018;
  localparam logic [15:0] INT_VEC3 = 16'h0020;
  // =====================================================
  // default internal memory size in words
  localparam int INT_MEM_WORDS = 8192;
  // phase encodings within an instruction cycle
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q3 = 2'h2;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  // control line positions on the control port
  localparam int CTL_ALE = 0;
  localparam int CTL_OE = 1;
  localparam int CTL_WR = 2;
  // output enable values (low drives)
  localparam logic [7:0] OE_DRIVE = 8'h00;
  localparam logic [7:0] OE_FLOAT = 8'hFF;
  localparam logic [2:0] CTL_IDLE = 3'h6;
endpackage

//--- testbench/pm_bus_asserts.sv
/* Checker for the program bus block.
 Bound to the top module; sees its ports only. */
`timescale 1ns/100ps
module pm_bus_asserts
  import pm_bus_pkg::*;
#(parameter int INT_WORDS = INT_MEM_WORDS) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic specialReq,
  input wire logic [7:0] busLowByteOe,
  input wire logic [7:0] busHighByteOe,
  input wire logic [2:0] busControlOut,
  input wire logic [2:0] busControlOe,
  input wire logic [15:0] intAddr,
  input wire logic intRead,
  input wire logic fetchValid,
  input wire logic codeProtect,
  input wire logic specialGrant,
  input wire logic [1:0] activeMode
);
  // ==========
  // bus cycle and mode checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire intOnly = activeMode inside {MODE_MICROCTRL, MODE_PROTECTED};
  sequence s_addr;
    $rose(busControlOut[CTL_ALE]);
  endsequence
  sequence s_rest;
    !busControlOut[CTL_ALE] ##1 !(busControlOut[CTL_OE] && busControlOut[CTL_WR])
      ##1 busControlOut == CTL_IDLE;
  endsequence
  chk_bus_cycle: assert property (s_addr |=> s_rest)
    else $error("bus cycle shape wrong");
  chk_addr_drive: assert property (s_addr |-> busLowByteOe == OE_DRIVE &&
    busHighByteOe == OE_DRIVE && busControlOe == 3'h0) else $error("address not driven");
  chk_bus_float: assert property (intOnly |-> busLowByteOe == OE_FLOAT &&
    busHighByteOe == OE_FLOAT && busControlOe == 3'h7) else $error("bus driven");
  chk_prot_flag: assert property ($past(rstn, 2) |->
    codeProtect == (activeMode == MODE_PROTECTED)) else $error("protect flag wrong");
  chk_mode_fixed: assert property ($past(rstn, 2) |-> $stable(activeMode))
    else $error("mode changed");
  chk_grant_gate: assert property (specialGrant |-> intOnly)
    else $error("grant in bus mode");
  chk_grant_give: assert property (specialReq && intOnly |=> specialGrant)
    else $error("grant missing");
  chk_proc_noint: assert property (activeMode == MODE_MICROPROC |-> !intRead)
    else $error("internal read in bus mode");
  chk_ext_split: assert property (intRead && activeMode == MODE_EXTENDED |->
    intAddr < INT_WORDS) else $error("internal read above split");
  chk_fetch_gap: assert property (fetchValid |=> !fetchValid [*3])
    else $error("fetches too close");
endmodule
bind program_memory_mode_ext_bus pm_bus_asserts #(.INT_WORDS(INT_WORDS)) i_chk (
  .sys_clk, .rstn, .specialReq, .busLowByteOe, .busHighByteOe, .busControlOut,
  .busControlOe, .intAddr, .intRead, .fetchValid, .codeProtect, .specialGrant, .activeMode
);

//--- testbench/pm_ext_memory.sv
/* Address latches plus external program memory.
 Assumes control lines pulled up while floated. */
`timescale 1ns/100ps
module pm_ext_memory
  import pm_bus_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [15:0] busOut,
  input wire logic [15:0] busOe,
  input wire logic [2:0] ctl,
  output logic [15:0] busPin,
  output logic [15:0] wrAddr,
  output logic [15:0] wrData
);
  // ==========
  // memory word is the swapped, inverted address
  logic [15:0] addr_q = 16'h0000;
  logic [15:0] last_q = 16'h0000;
  logic hold_q = 1'b0;
  wire rdOn = !ctl[CTL_OE] || hold_q;
  wire [15:0] farVal = rdOn ? ~{addr_q[7:0], addr_q[15:8]} : ~last_q;
  assign busPin = (~busOe & busOut) | (busOe & farVal);
  always @(posedge sys_clk) begin
    last_q <= busPin;
    hold_q <= !ctl[CTL_OE];
    if (ctl[CTL_ALE]) addr_q <= busPin;
    if (!ctl[CTL_WR]) begin
      wrAddr <= addr_q;
      wrData <= busPin;
    end
  end
endmodule

//--- testbench/tb_program_memory_mode_ext_bus.sv
/* Testbench for the program memory mode block.
 Assumes the external memory model beside it. */
`timescale 1ns/100ps
module tb_program_memory_mode_ext_bus
  import pm_bus_pkg::*;
;
  localparam int IW = 16;
  logic sys_clk = 1'b0, rstn = 1'b0, vecLoad = 1'b0, jumpLoad = 1'b0;
  logic tblWrite = 1'b0, specialReq = 1'b0, intRead, fetchValid, codeProtect, specialGrant;
  logic [1:0] modeCfg = 2'h3, vecSel = 2'h0, activeMode;
  logic [2:0] busControlOut, busControlOe;
  logic [7:0] busLowByteOut, busHighByteOut, busLowByteOe, busHighByteOe;
  logic [15:0] jumpAddr = 16'h0000, tblAddr = 16'h0000, tblData = 16'h0000;
  logic [15:0] intWord = 16'h0000, progCounter, intAddr, fetchWord, pin, wrAddr, wrData;
  int fails = 0;
  int cmp_count = 0;
  always #20 sys_clk = ~sys_clk;
  // internal memory: word follows its address
  always @(posedge sys_clk) intWord <= intAddr ^ 16'h0F0F;
  program_memory_mode_ext_bus #(.INT_WORDS(IW)) i_dut (
    .sys_clk, .rstn, .modeCfg, .vecLoad, .vecSel, .jumpLoad, .jumpAddr, .tblWrite, .tblAddr,
    .tblData, .specialReq, .intWord, .busLowByteIn(pin[7:0]), .busHighByteIn(pin[15:8]),
    .busLowByteOut, .busHighByteOut, .busLowByteOe, .busHighByteOe, .busControlOut,
    .busControlOe, .progCounter, .intAddr, .intRead, .fetchWord, .fetchValid, .codeProtect,
    .specialGrant, .activeMode
  );
  pm_ext_memory i_mem (.sys_clk, .busOut({busHighByteOut, busLowByteOut}),
    .busOe({busHighByteOe, busLowByteOe}), .ctl(busControlOut | busControlOe),
    .busPin(pin), .wrAddr, .wrData);
  // ==========
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [15:0] want(input logic [1:0] m, input logic [15:0] a);
    if (m == MODE_MICROPROC || (m == MODE_EXTENDED && a >= IW)) return ~{a[7:0], a[15:8]};
    return a ^ 16'h0F0F;
  endfunction
  task automatic reboot(input logic [1:0] m);
    @(posedge sys_clk) rstn <= 1'b0;
    modeCfg <= m;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    specialReq <= 1'b1;
  endtask
  task automatic waitFetch;
    int n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (fetchValid !== 1'b1 && n < 12);
    check({15'h0000, fetchValid}, 16'h0001);
  endtask
  task automatic go(input logic v, input logic [15:0] a);
    waitFetch;
    @(posedge sys_clk);
    vecLoad <= v;
    jumpLoad <= !v;
    jumpAddr <= a;
    waitFetch;
    @(posedge sys_clk);
    vecLoad <= 1'b0;
    jumpLoad <= 1'b0;
  endtask
  task automatic run(input logic [1:0] m, input logic [15:0] a, input int k);
    for (int i = 0; i < k; i++) begin
      waitFetch;
      check(fetchWord, want(m, a + 16'(i)));
      check(progCounter, a + 16'(i + 1));
    end
  endtask
  // ==========
  // scenarios
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      reboot(2'(m));
      @(posedge sys_clk) modeCfg <= ~2'(m);
      repeat (2) @(negedge sys_clk);
      check({14'h0000, activeMode}, 16'(m));
      check({15'h0000, codeProtect}, 16'(m == 0));
      check({15'h0000, specialGrant}, 16'(m < 2));
      check(progCounter, RESET_VECTOR);
      run(2'(m), RESET_VECTOR, 1);
    end
  endtask
  task automatic t_vectors;
    reboot(MODE_MICROPROC);
    for (int v = 0; v < 4; v++) begin
      @(posedge sys_clk) vecSel <= 2'(v);
      go(1'b1, 16'h0000);
      run(MODE_MICROPROC, 16'(8 * (v + 1)), 2);
    end
    go(1'b0, 16'hFFFE);
    run(MODE_MICROPROC, 16'hFFFE, 2);
  endtask
  task automatic t_write;
    @(posedge sys_clk);
    tblAddr <= 16'hA55A;
    tblData <= 16'h3CC3;
    tblWrite <= 1'b1;
    repeat (4) @(posedge sys_clk);
    tblWrite <= 1'b0;
    for (int i = 0; i < 12 && wrData !== 16'h3CC3; i++) @(negedge sys_clk);
    check(wrAddr, 16'hA55A);
    check(wrData, 16'h3CC3);
  endtask
  task automatic t_split;
    reboot(MODE_EXTENDED);
    go(1'b0, 16'(IW - 2));
    run(MODE_EXTENDED, 16'(IW - 2), 4);
    reboot(MODE_MICROCTRL);
    go(1'b0, 16'h0005);
    run(MODE_MICROCTRL, 16'h0005, 2);
  endtask
  initial begin
    t_modes;
    t_vectors;
    t_write;
    t_split;
    summarize;
  end
  initial begin
    #100000;
    fails++;
    summarize;
  end
endmodule
